// *** core/ptcs_pkg.sv ***
// Shared constants and types for the peer-to-peer transparent clock stamper.
// Assumes untagged Ethernet frames carrying PTP directly after the EtherType.
package ptcs_pkg;

    // Frame byte positions, counted from the first destination address byte
    localparam logic [10:0] POS_ETYPE_HI = 11'h00C;
    localparam logic [10:0] POS_ETYPE_LO = 11'h00D;
    localparam logic [10:0] POS_MSGTYPE  = 11'h00E;
    localparam logic [10:0] POS_DOMAIN   = 11'h012;
    localparam logic [10:0] POS_CF       = 11'h016;
    localparam logic [10:0] CF_BYTES     = 11'h008;
    localparam logic [10:0] POS_RSV      = 11'h01E;
    localparam logic [10:0] RSV_BYTES    = 11'h004;
    localparam logic [10:0] POS_CALC     = 11'h022;
    localparam logic [10:0] POS_SEQ      = 11'h02C;
    localparam logic [10:0] SEQ_BYTES    = 11'h002;
    localparam logic [10:0] IDX_MAX      = 11'h7FF;
    localparam logic [10:0] FCS_LEAD     = 11'h003;

    localparam logic [15:0] ETH_TYPE_PTP    = 16'h88F7;
    localparam logic [3:0]  MSG_SYNC        = 4'h0;
    localparam logic [3:0]  MSG_PDELAY_REQ  = 4'h2;
    localparam logic [3:0]  MSG_PDELAY_RESP = 4'h3;

    localparam logic [31:0] CRC_INIT    = 32'hFFFF_FFFF;
    localparam logic [31:0] CRC_POLY    = 32'hEDB8_8320;
    localparam logic [31:0] CRC_RESIDUE = 32'hDEBB_20E3;
    localparam logic [31:0] NS_PER_SEC  = 32'h3B9A_CA00;

    localparam int DLY_DEPTH  = 16;
    localparam int FIFO_DEPTH = 4;
    localparam int FIFO_AW    = 2;

    // Register byte offsets
    localparam logic [7:0] REG_CTRL       = 8'h00;
    localparam logic [7:0] REG_LINK_DELAY = 8'h04;
    localparam logic [7:0] REG_ASYM       = 8'h08;
    localparam logic [7:0] REG_LOCAL_CORR = 8'h0C;
    localparam logic [7:0] REG_STATUS     = 8'h10;
    localparam logic [7:0] REG_FIFO_SEQ   = 8'h14;
    localparam logic [7:0] REG_FIFO_STAMP = 8'h18;

    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

    typedef enum logic [5:0] {
        ACT_IGNORE             = 6'b000001,
        ACT_SUB_LINK_DELAY     = 6'b000010,
        ACT_WRITE              = 6'b000100,
        ACT_WRITE_SAVE         = 6'b001000,
        ACT_ADD                = 6'b010000,
        ACT_SUB_ADD            = 6'b100000
    } ptcs_action_t;

    typedef struct packed {
        logic       valid;
        logic       last;
        logic [7:0] data;
    } ptcs_byte_t;

    typedef struct packed {
        logic [15:0] seq;
        logic [31:0] stamp;
    } ptcs_stamp_rec_t;

    // CTRL layout: bit0 egress, bit1 mode B, bit2 normal t3, bits 15:8 domain
    typedef struct packed {
        logic [15:0] unused;
        logic [7:0]  domain;
        logic [4:0]  spare;
        logic        t3_normal;
        logic        mode_b;
        logic        egress;
    } ptcs_cfg_t;

endpackage

// *** core/ptcs_crc.sv ***
// Byte-wide Ethernet CRC-32 accumulator, reflected form.
// Assumes the caller pulses clear_i together with the first byte of a frame.
`timescale 1ns/1ps
`default_nettype none
module ptcs_crc (
    input  wire logic        core_clk_i,
    input  wire logic        rst_i,
    input  wire logic        clear_i,
    input  wire logic        en_i,
    input  wire logic [7:0]  data_i,
    output var  logic [31:0] crc_o
);
    import ptcs_pkg::*;

    function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [7:0] d);
        logic [31:0] r;
        r = c ^ {24'h00_0000, d};
        for (int i = 0; i < 8; i++) begin
            r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
        end
        return r;
    endfunction

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            crc_o <= CRC_INIT;
        end else if (en_i) begin
            crc_o <= crc_step(clear_i ? CRC_INIT : crc_o, data_i);
        end
    end

endmodule
`default_nettype wire

// *** core/ptcs_core.sv ***
// Per-port PTP stamper for a one-step peer-to-peer transparent clock.
// Assumes one byte stream per port on core_clk_i and a stamp input valid at the first byte.
//
// Implementation choices: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Sync crossing gains residence time and the arrival port link delay.
// - Modified t3 egress adds actual minus inserted stamp into the correction field.
// - Ingress Sync mode A: subtract stamp, add link delay, hand to rewriter.
// - Correction field rewrites use its frame offset and eight bytes.
// - Ingress Sync: field minus stamp plus local correction, plus link delay and asymmetry.
// - Ingress peer delay frames mode A: write receive nanoseconds into reserved bytes.
// - Ingress response mode A also adds asymmetry to the correction field.
// - Egress Sync mode A: add stamp plus local correction.
// - Egress request: add transmit stamp, subtract reserved stamp and asymmetry.
// - Egress response: add transmit stamp, subtract reserved stamp.
// - Normal t3: request frame unaltered, sequence and stamp saved in FIFO.
// - Unmatched frames pass unchanged and their stamp is dropped.
// - Ingress Sync mode B subtracts the peer live stamp from the field.
// - Ingress peer delay mode B writes live stamp, responses plus asymmetry.
// - Modified frames get a freshly computed check sequence.
// - A modified frame arriving with a bad check sequence leaves with it inverted; unmodified frames keep the original.
module ptcs_core (
    input  wire logic                 core_clk_i,
    input  wire logic                 rst_i,
    input  wire ptcs_pkg::ptcs_byte_t in_i,
    output var  logic                 in_ready_o,
    input  wire logic [31:0]          unadjusted_stamp_nanos_i,
    output var  ptcs_pkg::ptcs_byte_t out_o,
    input  wire logic [7:0]           reg_addr_i,
    input  wire logic [31:0]          reg_wdata_i,
    input  wire logic                 reg_wr_i,
    input  wire logic                 reg_rd_i,
    output var  logic [31:0]          reg_rdata_o
);
    import ptcs_pkg::*;

    ptcs_cfg_t       cfg;
    logic [31:0]     link_delay;
    logic [31:0]     asym;
    logic [31:0]     local_corr;
    ptcs_byte_t      dly [DLY_DEPTH];
    ptcs_byte_t      tail;
    logic            acc;
    logic            advance;
    logic            emit;
    logic            calc_now;
    logic [10:0]     in_idx;
    logic [10:0]     in_len;
    logic            len_ok;
    logic [10:0]     out_idx;
    ptcs_action_t    act;
    logic            rw_cf;
    logic            rw_rsv;
    logic            modified;
    logic            etype_ok;
    logic [3:0]      msg;
    logic [63:0]     cf_orig;
    logic [63:0]     cf_new;
    logic [31:0]     rsv_orig;
    logic [31:0]     rsv_new;
    logic [31:0]     live_stamp_nanos;
    logic [31:0]     live_stamp_nanos_peer;
    logic [31:0]     sa_diff;
    logic [15:0]     seq;
    logic [31:0]     crc_in;
    logic [31:0]     crc_out;
    logic [31:0]     fcs_val;
    logic            chk_pending;
    logic            orig_bad;
    ptcs_stamp_rec_t fifo_mem [FIFO_DEPTH];
    logic [FIFO_AW:0] wr_ptr;
    logic [FIFO_AW:0] rd_ptr;
    logic [FIFO_AW:0] level;
    logic            push;
    logic            pop;
    logic [10:0]     cf_off;
    logic [10:0]     rsv_off;
    logic [10:0]     fcs_off;
    logic            fcs_pos;
    logic [63:0]     cf_sh;
    logic [31:0]     rsv_sh;
    logic [31:0]     fcs_sh;
    logic [7:0]      next_byte;

    // Nanoseconds to correction field units, sign kept
    function automatic logic [63:0] ns_to_cf(input logic [31:0] ns);
        return {{16{ns[31]}}, ns, 16'h0000};
    endfunction

    function automatic logic in_win(input logic [10:0] idx, input logic [10:0] base, input logic [10:0] n);
        return (idx >= base) && (idx < base + n);
    endfunction

    assign tail     = dly[DLY_DEPTH-1];
    assign acc      = in_i.valid && in_ready_o;
    assign advance  = acc || !in_ready_o;
    assign emit     = advance && tail.valid;
    assign calc_now = acc && (in_idx == POS_CALC);
    assign modified = rw_cf || rw_rsv;
    assign level    = wr_ptr - rd_ptr;
    assign push     = acc && in_i.last && (act == ACT_WRITE_SAVE) && (level != (FIFO_AW+1)'(FIFO_DEPTH));
    assign pop      = reg_rd_i && (reg_addr_i == REG_FIFO_STAMP) && (level != '0);
    // Reserved bytes hold only sub-second time, so the difference wraps at one second
    assign sa_diff  = (live_stamp_nanos >= rsv_orig) ? live_stamp_nanos - rsv_orig
                                                     : live_stamp_nanos + NS_PER_SEC - rsv_orig;

    // Delay line gives the rewriter time to see the reserved bytes before the field leaves
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            for (int i = 0; i < DLY_DEPTH; i++) begin
                dly[i] <= '0;
            end
        end else if (advance) begin
            dly[0] <= '{valid: acc, last: acc && in_i.last, data: in_i.data};
            for (int i = 1; i < DLY_DEPTH; i++) begin
                dly[i] <= dly[i-1];
            end
        end
    end

    // One frame in flight at a time: stall input until the tail has drained
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            in_ready_o <= 1'b1;
        end else if (acc && in_i.last) begin
            in_ready_o <= 1'b0;
        end else if (emit && tail.last) begin
            in_ready_o <= 1'b1;
        end
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            in_idx <= '0;
            in_len <= '0;
            len_ok <= 1'b0;
        end else begin
            if (acc) begin
                in_idx <= in_i.last ? 11'h000 : ((in_idx == IDX_MAX) ? in_idx : in_idx + 11'h001);
            end
            if (acc && in_i.last) begin
                in_len <= in_idx;
                len_ok <= 1'b1;
            end else if (emit && tail.last) begin
                len_ok <= 1'b0;
            end
        end
    end

    // Analyzer: classify the frame and choose the timestamp action
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            act      <= ACT_IGNORE;
            rw_cf    <= 1'b0;
            rw_rsv   <= 1'b0;
            etype_ok <= 1'b0;
            msg      <= 4'h0;
        end else if (acc) begin
            if (in_idx == 11'h000) begin
                act      <= ACT_IGNORE;
                rw_cf    <= 1'b0;
                rw_rsv   <= 1'b0;
                etype_ok <= 1'b0;
            end
            if (in_idx == POS_ETYPE_HI) begin
                etype_ok <= (in_i.data == ETH_TYPE_PTP[15:8]);
            end
            if (in_idx == POS_ETYPE_LO) begin
                etype_ok <= etype_ok && (in_i.data == ETH_TYPE_PTP[7:0]);
            end
            if (in_idx == POS_MSGTYPE) begin
                msg <= in_i.data[3:0];
            end
            if ((in_idx == POS_DOMAIN) && etype_ok && (in_i.data == cfg.domain)) begin
                if (!cfg.egress) begin
                    if (msg == MSG_SYNC) begin
                        act   <= ACT_SUB_LINK_DELAY;
                        rw_cf <= 1'b1;
                    end else if ((msg == MSG_PDELAY_REQ) || (msg == MSG_PDELAY_RESP)) begin
                        act    <= ACT_WRITE;
                        rw_rsv <= 1'b1;
                        rw_cf  <= (msg == MSG_PDELAY_RESP) && !cfg.mode_b;
                    end
                end else begin
                    if (msg == MSG_SYNC) begin
                        act   <= ACT_ADD;
                        rw_cf <= 1'b1;
                    end else if ((msg == MSG_PDELAY_REQ) && cfg.t3_normal) begin
                        act <= ACT_WRITE_SAVE;
                    end else if ((msg == MSG_PDELAY_REQ) || (msg == MSG_PDELAY_RESP)) begin
                        act    <= ACT_SUB_ADD;
                        rw_cf  <= 1'b1;
                        rw_rsv <= (msg == MSG_PDELAY_REQ);
                    end
                end
            end
        end
    end

    // Field capture and live stamps latched at the first byte
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cf_orig               <= '0;
            rsv_orig              <= '0;
            seq                   <= '0;
            live_stamp_nanos      <= '0;
            live_stamp_nanos_peer <= '0;
        end else if (acc) begin
            if (in_idx == 11'h000) begin
                live_stamp_nanos      <= unadjusted_stamp_nanos_i + local_corr;
                live_stamp_nanos_peer <= unadjusted_stamp_nanos_i + local_corr - link_delay - asym;
            end
            if (in_win(in_idx, POS_CF, CF_BYTES)) begin
                cf_orig <= {cf_orig[55:0], in_i.data};
            end
            if (in_win(in_idx, POS_RSV, RSV_BYTES)) begin
                rsv_orig <= {rsv_orig[23:0], in_i.data};
            end
            if (in_win(in_idx, POS_SEQ, SEQ_BYTES)) begin
                seq <= {seq[7:0], in_i.data};
            end
        end
    end

    // Timestamp unit: new field values once both fields have been seen
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cf_new  <= '0;
            rsv_new <= '0;
        end else if (calc_now) begin
            unique case (act)
                ACT_SUB_LINK_DELAY: begin
                    if (cfg.mode_b) begin
                        cf_new <= cf_orig - ns_to_cf(live_stamp_nanos_peer);
                    end else begin
                        cf_new <= cf_orig - ns_to_cf(live_stamp_nanos)
                                + ns_to_cf(link_delay) + ns_to_cf(asym);
                    end
                end
                ACT_WRITE: begin
                    rsv_new <= (cfg.mode_b && (msg == MSG_PDELAY_RESP)) ? live_stamp_nanos + asym
                                                                         : live_stamp_nanos;
                    cf_new  <= cf_orig + ns_to_cf(asym);
                end
                ACT_ADD: begin
                    cf_new <= cf_orig + ns_to_cf(live_stamp_nanos);
                end
                ACT_SUB_ADD: begin
                    // Request field arrives as zero from the engine
                    cf_new  <= cf_orig + ns_to_cf(sa_diff)
                             - ((msg == MSG_PDELAY_REQ) ? ns_to_cf(asym) : 64'h0000_0000_0000_0000);
                    rsv_new <= '0;
                end
                ACT_WRITE_SAVE, ACT_IGNORE: begin
                end
            endcase
        end
    end

    ptcs_crc u_crc_in (
        .core_clk_i (core_clk_i),
        .rst_i      (rst_i),
        .clear_i    (in_idx == 11'h000),
        .en_i       (acc),
        .data_i     (in_i.data),
        .crc_o      (crc_in)
    );

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            chk_pending <= 1'b0;
            orig_bad    <= 1'b0;
        end else begin
            chk_pending <= acc && in_i.last;
            if (chk_pending) begin
                orig_bad <= (crc_in != CRC_RESIDUE);
            end
        end
    end

    // Rewriter
    assign cf_off  = out_idx - POS_CF;
    assign rsv_off = out_idx - POS_RSV;
    assign fcs_off = out_idx + FCS_LEAD - in_len;
    assign fcs_pos = len_ok && ({1'b0, out_idx} + {1'b0, FCS_LEAD} >= {1'b0, in_len});
    assign fcs_val = orig_bad ? crc_out : ~crc_out;
    assign cf_sh   = cf_new >> {~cf_off[2:0], 3'b000};
    assign rsv_sh  = rsv_new >> {~rsv_off[1:0], 3'b000};
    assign fcs_sh  = fcs_val >> {fcs_off[1:0], 3'b000};

    always_comb begin
        next_byte = tail.data;
        if (modified && fcs_pos) begin
            next_byte = fcs_sh[7:0];
        end else if (rw_cf && in_win(out_idx, POS_CF, CF_BYTES)) begin
            next_byte = cf_sh[7:0];
        end else if (rw_rsv && in_win(out_idx, POS_RSV, RSV_BYTES)) begin
            next_byte = rsv_sh[7:0];
        end
    end

    ptcs_crc u_crc_out (
        .core_clk_i (core_clk_i),
        .rst_i      (rst_i),
        .clear_i    (out_idx == 11'h000),
        .en_i       (emit && !fcs_pos),
        .data_i     (next_byte),
        .crc_o      (crc_out)
    );

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            out_o   <= '0;
            out_idx <= '0;
        end else begin
            out_o <= '{valid: emit, last: emit && tail.last, data: next_byte};
            if (emit) begin
                out_idx <= tail.last ? 11'h000 : ((out_idx == IDX_MAX) ? out_idx : out_idx + 11'h001);
            end
        end
    end

    // Transmit stamp FIFO; a push into a full FIFO is dropped
    always_ff @(posedge core_clk_i) begin
        if (push) begin
            fifo_mem[wr_ptr[FIFO_AW-1:0]] <= '{seq: seq, stamp: live_stamp_nanos};
        end
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
        end
    end

    // Register port
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cfg        <= CTRL_RESET;
            link_delay <= '0;
            asym       <= '0;
            local_corr <= '0;
        end else if (reg_wr_i) begin
            case (reg_addr_i)
                REG_CTRL:       cfg        <= reg_wdata_i;
                REG_LINK_DELAY: link_delay <= reg_wdata_i;
                REG_ASYM:       asym       <= reg_wdata_i;
                REG_LOCAL_CORR: local_corr <= reg_wdata_i;
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            reg_rdata_o <= '0;
        end else if (!reg_rd_i) begin
            reg_rdata_o <= '0;
        end else begin
            case (reg_addr_i)
                REG_CTRL:       reg_rdata_o <= cfg;
                REG_LINK_DELAY: reg_rdata_o <= link_delay;
                REG_ASYM:       reg_rdata_o <= asym;
                REG_LOCAL_CORR: reg_rdata_o <= local_corr;
                REG_STATUS:     reg_rdata_o <= {16'h0000, orig_bad, !in_ready_o, act, 5'h00, level};
                REG_FIFO_SEQ:   reg_rdata_o <= {16'h0000, fifo_mem[rd_ptr[FIFO_AW-1:0]].seq};
                REG_FIFO_STAMP: reg_rdata_o <= fifo_mem[rd_ptr[FIFO_AW-1:0]].stamp;
                default:        reg_rdata_o <= '0;
            endcase
        end
    end

    default clocking @(posedge core_clk_i); endclocking
    default disable iff (rst_i);

    sequence s_eof_taken;
        acc && in_i.last;
    endsequence

    sequence s_fcs_first;
        emit && modified && fcs_pos && (fcs_off[1:0] == 2'b00);
    endsequence

    a_stall_after_eof: assert property (s_eof_taken |=> !in_ready_o)
        else $error("input not stalled after end of frame");
    a_sync_modes_agree: assert property (calc_now && act == ACT_SUB_LINK_DELAY |=>
        cf_new == $past(cf_orig) - ns_to_cf($past(live_stamp_nanos_peer)))
        else $error("ingress sync correction mismatch");
    a_egress_add_cf: assert property (calc_now && act == ACT_ADD |=>
        cf_new - $past(cf_orig) == ns_to_cf($past(live_stamp_nanos)))
        else $error("egress sync add wrong");
    a_resp_asym_add: assert property (calc_now && act == ACT_WRITE && !cfg.mode_b |=>
        cf_new - $past(cf_orig) == ns_to_cf($past(asym)))
        else $error("response asymmetry not added");
    a_ignored_passes: assert property (emit && !modified |=> out_o.data == $past(tail.data))
        else $error("unmatched frame altered");
    a_write_hits_rsv: assert property (act == ACT_WRITE |-> rw_rsv)
        else $error("write action without reserved rewrite");
    a_save_no_rewrite: assert property (act == ACT_WRITE_SAVE |-> !rw_cf && !rw_rsv)
        else $error("saved request frame is being modified");
    a_fifo_push_one: assert property (push && !pop |=> level == $past(level) + 1'b1)
        else $error("stamp fifo did not grow");
    a_fcs_bad_kept: assert property (s_fcs_first |=>
        out_o.data == ($past(orig_bad) ? $past(crc_out[7:0]) : ~$past(crc_out[7:0])))
        else $error("check sequence polarity wrong");
    a_rdata_idle_zero: assert property (!reg_rd_i |=> reg_rdata_o == 32'h0000_0000)
        else $error("read data outside read slot");

endmodule
`default_nettype wire

// *** testbench/ptcs_peer.sv ***
// Peer node model: streams frames into the stamper and gathers the bytes it emits.
// Assumes the caller enters send just after a rising edge, one frame in flight.
`timescale 1ns/1ps
`default_nettype none
module ptcs_peer (
    input  wire logic                 core_clk_i,
    input  wire logic                 in_ready_i,
    input  wire ptcs_pkg::ptcs_byte_t out_i,
    output var  ptcs_pkg::ptcs_byte_t in_o,
    output var  logic [31:0]          stamp_o
);
    import ptcs_pkg::*;
    logic [7:0] rx_q[$];
    int         seed = 36009;
    int         last_at = -1;
    initial begin
        in_o = '0;
        stamp_o = '0;
    end
    always @(posedge core_clk_i) begin
        if (out_i.valid === 1'b1) begin
            // First end marker only, so an early one is caught
            if (out_i.last === 1'b1 && last_at < 0) last_at = rx_q.size();
            rx_q.push_back(out_i.data);
        end
    end
    task automatic send(input logic [7:0] f[$], input logic [31:0] st);
        foreach (f[i]) begin
            in_o <= {1'b1, 1'(i == f.size() - 1), f[i]};
            stamp_o <= st;
            // Ready is a register, so judge it mid-cycle to avoid an edge race
            do @(negedge core_clk_i); while (in_ready_i !== 1'b1);
            @(posedge core_clk_i);
            if ($random(seed) & 1) begin
                in_o <= {2'b00, ~f[i]};
                @(posedge core_clk_i);
            end
        end
        // Idle lines never repeat the last byte, so stale data cannot pass
        in_o <= {2'b00, ~f[f.size() - 1]};
        stamp_o <= ~st;
    endtask
endmodule
`default_nettype wire

// *** testbench/ptcs_core_tb_top.sv ***
// Self-checking bench: every frame kind through the stamper against a byte model.
// Assumes ptcs_peer drives the stream side; registers via plain strobes.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin miscompares++; $display("wrong value at %0t: mismatch", $time); end end
module ptcs_core_tb_top;
    import ptcs_pkg::*;
    logic        core_clk_i = 1'b0;
    logic        rst_i = 1'b1;
    ptcs_byte_t  in_b, out_b;
    logic        in_ready, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
    logic [31:0] stamp, reg_rdata_o, r, reg_wdata_i = '0;
    logic [7:0]  reg_addr_i = '0;
    int          miscompares = 0, checks_done = 0, cycles = 0, seed = 36009, link, asym, lc;
    logic [7:0]  cases [17] = '{8'h00, 8'h08, 8'h02, 8'h03, 8'h0A, 8'h0B, 8'h04, 8'h06, 8'h16, 8'h07,
                                8'h01, 8'h20, 8'h21, 8'h26, 8'h0C, 8'h40, 8'h84};
    initial forever #5 core_clk_i = ~core_clk_i;
    ptcs_core u_dut (.core_clk_i(core_clk_i), .rst_i(rst_i), .in_i(in_b), .in_ready_o(in_ready),
        .unadjusted_stamp_nanos_i(stamp), .out_o(out_b), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o));
    ptcs_peer u_peer (.core_clk_i(core_clk_i), .in_ready_i(in_ready), .out_i(out_b), .in_o(in_b),
        .stamp_o(stamp));
    task automatic print_verdict();
        if (miscompares == 0 && checks_done > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    always @(posedge core_clk_i) begin
        cycles++;
        if (cycles == 12000) begin
            miscompares++;
            print_verdict();
        end
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge core_clk_i);
        reg_wr_i <= 1'b0;
        @(posedge core_clk_i);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge core_clk_i);
        reg_rd_i <= 1'b0;
        @(negedge core_clk_i);
        d = reg_rdata_o;
        @(posedge core_clk_i);
    endtask
    function automatic logic [31:0] crc(input logic [7:0] q[$]);
        logic [31:0] c = CRC_INIT;
        foreach (q[i]) for (int b = 0; b < 8; b++) c = (c >> 1) ^ ((c[0] ^ q[i][b]) ? CRC_POLY : 32'h0000_0000);
        return ~c;
    endfunction
    function automatic void add_fcs(ref logic [7:0] q[$], input logic [31:0] v);
        for (int b = 0; b < 4; b++) q.push_back(v[8*b+:8]);
    endfunction
    // Code bits: [1:0] message, [2] egress, [3] mode B, [4] normal t3, [5] bad check sequence,
    // [6] foreign domain, [7] non-PTP type
    task automatic run(input logic [7:0] c);
        logic [7:0]  f[$], e[$];
        logic [31:0] raw, rn;
        logic [5:0]  act;
        int          s, d, rsv;
        longint      cf;
        raw = {$random(seed)} % NS_PER_SEC;
        rsv = {$random(seed)} % NS_PER_SEC;
        wr(REG_CTRL, {24'h00_0000, 5'h00, c[4:2]});
        for (int i = 0; i < 60; i++) f.push_back(8'($random(seed)));
        {f[12], f[13], f[14]} = {ETH_TYPE_PTP ^ {15'h0000, c[7]}, 6'h00, c[1:0]};
        f[18] = {7'h00, c[6]};
        // Engine-style request: zero correction, soft stamp in reserved bytes
        for (int i = 22; i < 30; i++) f[i] = (i < 27 || c[2:0] == 3'b110) ? 8'h00 : f[i];
        {f[30], f[31], f[32], f[33]} = rsv;
        cf = {f[22], f[23], f[24], f[25], f[26], f[27], f[28], f[29]};
        s = raw + lc;
        d = (s - rsv < 0) ? s - rsv + int'(NS_PER_SEC) : s - rsv;
        rn = rsv;
        case ((c[7:6] != 2'b00) ? 3'b001 : c[2:0])
            3'b000: begin cf += longint'(link + asym - s) <<< 16; act = 6'h02; end
            3'b010: begin rn = s; act = 6'h04; end
            3'b011: begin rn = s + (c[3] ? asym : 0); cf += longint'(c[3] ? 0 : asym) <<< 16; act = 6'h04; end
            3'b100: begin cf += longint'(s) <<< 16; act = 6'h10; end
            3'b110: begin
                act = c[4] ? 6'h08 : 6'h20;
                if (!c[4]) cf += longint'(d - asym) <<< 16;
                if (!c[4]) rn = 0;
            end
            3'b111: begin cf += longint'(d) <<< 16; act = 6'h20; end
            default: act = 6'h01;
        endcase
        e = f;
        {e[22], e[23], e[24], e[25], e[26], e[27], e[28], e[29]} = cf;
        {e[30], e[31], e[32], e[33]} = rn;
        add_fcs(f, crc(f) ^ 32'(c[5]));
        add_fcs(e, (act[0] | act[3]) ? {f[63], f[62], f[61], f[60]} : crc(e) ^ {32{c[5]}});
        u_peer.send(f, raw);
        for (int w = 0; w < 300 && u_peer.rx_q.size() < 64; w++) @(posedge core_clk_i);
        `CHK(u_peer.rx_q.size(), 64)
        `CHK(u_peer.last_at, 63)
        foreach (e[i]) `CHK(u_peer.rx_q[i], e[i])
        u_peer.rx_q.delete();
        u_peer.last_at = -1;
        rd(REG_STATUS, r);
        `CHK({r[15:8], r[2:0]}, {c[5], 1'b0, act, 2'b00, act[3]})
        if (act[3]) begin
            rd(REG_FIFO_SEQ, r);
            `CHK(r[15:0], {f[44], f[45]})
            rd(REG_FIFO_STAMP, r);
            `CHK(r, 32'(s))
        end
    endtask
    initial begin
        repeat (5) @(posedge core_clk_i);
        rst_i <= 1'b0;
        link = $random(seed) & 32'h0000_0FFF;
        asym = $random(seed) >>> 24;
        lc = $random(seed) >>> 24;
        wr(REG_LINK_DELAY, link);
        wr(REG_ASYM, asym);
        wr(REG_LOCAL_CORR, lc);
        rd(8'h40, r);
        `CHK(r, 32'h0000_0000)
        foreach (cases[k]) run(cases[k]);
        print_verdict();
    end
endmodule
`default_nettype wire
